/* File: inc/mmd_pkg.sv */
/*
 * Shared constants and carrier types for the memory map decoder:
 * region boundaries of the 24-bit space, field positions and types.
 * Assumes a single 40 MHz clock domain and byte addresses.
 */
package mmd_pkg;
    localparam int AW = 24;
    localparam logic [23:0] IMB_LO = 24'hffff00;
    localparam logic [23:0] IMB_HI = 24'hffffff;
    localparam logic [23:0] EPS_LO = 24'he80000;
    localparam logic [23:0] EPS_HI = 24'he9bfff;
    localparam logic [23:0] EPS_MIR_HI = 24'hefffff;
    localparam logic [23:0] PS_LO = 24'he00000;
    localparam logic [23:0] PS_HI = 24'he1bfff;
    localparam logic [23:0] PS_MIR_HI = 24'he7ffff;
    localparam logic [23:0] RAM_SIZE = 24'h01c000;
    localparam int MIRROR_WRAPS = 4;
    localparam logic [23:0] FL_LO = 24'hc00000;
    localparam logic [23:0] FL_HI = 24'hd8ffff;
    localparam logic [23:0] FL6_LO = 24'hd80000;
    localparam logic [2:0] FL6_MOD = 3'h6;
    localparam logic [23:0] CTL_LO = 24'hc0f000;
    localparam logic [23:0] CTL_HI = 24'hc0ffff;
    localparam logic [23:0] XM_LO = 24'h400000;
    localparam logic [23:0] XM_HI = 24'hbfffff;
    localparam logic [23:0] IO_LO = 24'h210000;
    localparam logic [23:0] IO_HI = 24'h3fffff;
    localparam logic [23:0] LX_LO = 24'h200000;
    localparam logic [23:0] LX_HI = 24'h20bfff;
    localparam logic [23:0] LX_GAP_LO = 24'h206800;
    localparam logic [23:0] LX_GAP_HI = 24'h207fff;
    localparam logic [23:0] XL_LO = 24'h010000;
    localparam logic [23:0] XL_HI = 24'h1fffff;
    localparam logic [23:0] SPF_LO = 24'h00fe00;
    localparam logic [23:0] SPF_HI = 24'h00ffff;
    localparam logic [23:0] DP_LO = 24'h00f600;
    localparam logic [23:0] DP_HI = 24'h00fdff;
    localparam logic [23:0] DP_BIT_LO = 24'h00fd00;
    localparam logic [23:0] EXF_LO = 24'h00f000;
    localparam logic [23:0] EXF_HI = 24'h00f1ff;
    localparam logic [23:0] XR_LO = 24'h00e000;
    localparam logic [23:0] XR_HI = 24'h00efff;
    localparam logic [23:0] DS_LO = 24'h008000;
    localparam logic [23:0] DS_HI = 24'h00dfff;
    localparam logic [23:0] GPR_LAST = 24'h00001f;
    localparam logic [3:0] GPR_BYTE_MAX = 4'h7;
    localparam int FL_MODS = 7;
    localparam int CLUS_PER_MOD = 16;
    localparam int CLUS_W = FL_MODS * CLUS_PER_MOD;

    typedef enum logic [3:0] {
        TGT_RSV = 4'h0,
        TGT_EXT = 4'h1,
        TGT_FLASH = 4'h2,
        TGT_PROG_RAM = 4'h3,
        TGT_EMU_RAM = 4'h4,
        TGT_DATA_RAM = 4'h5,
        TGT_DUAL_RAM = 4'h6,
        TGT_SPECIAL = 4'h7,
        TGT_EXTENDED = 4'h8,
        TGT_XREG = 4'h9,
        TGT_LOCAL_BUS = 4'ha,
        TGT_IMB_REGS = 4'hb
    } mmd_tgt_t;

    typedef enum logic [1:0] {
        PW_LOCKED = 2'h0,
        PW_HALF = 2'h1,
        PW_OPEN = 2'h2
    } mmd_pw_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic word;
        logic [23:0] addr;
    } mmd_req_t;

    typedef struct packed {
        logic valid;
        logic wr;
        mmd_tgt_t tgt;
        logic ext_cycle;
        logic strict;
        logic sys_bus;
        logic mirror;
        logic blocked;
        logic bit_ok;
        logic gpr_hit;
        logic [3:0] general_purpose_register;
        logic [7:0] seg;
        logic [1:0] page;
        logic [2:0] fmod;
        logic [5:0] fsec;
        logic [4:0] fblk;
        logic [23:0] off;
    } mmd_rsp_t;
endpackage

/* File: src/mmd_ecc.sv */
/*
 * Single-error-correcting Hamming check of one read word, plus a
 * plain even-parity check over the data and check bit 0.
 * Assumes check bit k sits at code position 2**k; purely combinational.
 */
`timescale 1ns/100ps
module mmd_ecc #(
    parameter int DW = 16,
    parameter int CW = 5
) (
    input logic [DW-1:0] data,
    input logic [CW-1:0] chk,
    output logic [DW-1:0] fixed,
    output logic single_err,
    output logic par_err
);
    logic [CW-1:0] syn;

    // Code position of data bit i, skipping powers of two
    function automatic logic [CW-1:0] dpos(input int i);
        int p;
        p = i + 1;
        for (int k = 0; k < CW; k++) begin
            if (p >= (1 << k)) begin
                p = p + 1;
            end
        end
        return p[CW-1:0];
    endfunction

    always_comb begin
        syn = chk;
        for (int i = 0; i < DW; i++) begin
            if (data[i]) begin
                syn = syn ^ dpos(i);
            end
        end
    end

    always_comb begin
        for (int i = 0; i < DW; i++) begin
            fixed[i] = data[i] ^ (syn == dpos(i));
        end
    end

    assign single_err = |syn;
    assign par_err = ^{data, chk[0]};
endmodule

/* File: src/mmd_decoder.sv */
/*
 * Address decoder and router for the unified 24-bit space: two request
 * ports (code fetch unit, data transfer unit), Flash unlock sequence and
 * read-data checking for Flash and on-chip SRAM.
 * Assumes requests and configuration come from logic on clk.
 */
// What this block does
// - 16 MB space, 64K segments, 16K pages
// - Byte and word accesses accepted, except byte to R8-R15
// - Reserved accesses go external or blocked
// - Flash control sector withheld from use
// - External IO region accesses strictly ordered
// - Data memories and registers in segment 0
// - Fetch unit owns program memory access
// - Data unit owns data RAM, peripherals
// - System bus joins both units concurrently
// - Program RAM protected section blocks writes
// - Dual-port RAM top, GPRs bit addressable
// - Sixteen word GPRs, eight byte-split
// - Flash is 64K plus six 256K modules
// - Sectors erased, programmed in 128-byte blocks
// - Write protect per cluster, erase per sector
// - Flash read protection, password unlocks temporarily
// - Wide Flash reads, modules work in parallel
// - Every Flash read passes error correction
// - Parity error blocks use of SRAM data when ECC is off
// - ECC corrects single-bit errors automatically
`timescale 1ns/100ps
module mmd_decoder #(
    parameter int FLASH_W = 128,
    parameter int FLASH_CW = 8,
    parameter int SRAM_W = 16,
    parameter int SRAM_CW = 5
) (
    input logic clk,
    input logic reset_n,
    input mmd_pkg::mmd_req_t fetch_req,
    input mmd_pkg::mmd_req_t data_req,
    output logic fetch_ready,
    output logic data_ready,
    output mmd_pkg::mmd_rsp_t fetch_rsp,
    output mmd_pkg::mmd_rsp_t data_rsp,
    input logic ext_bus_en,
    input logic [23:0] context_ptr,
    input logic [23:0] prog_ram_wp_size,
    input logic [mmd_pkg::CLUS_W-1:0] flash_wp,
    input logic read_prot_en,
    input logic pw_strobe,
    input logic [15:0] pw_word,
    input logic [31:0] pw_key,
    input logic relock,
    input logic flash_rvalid,
    input logic [FLASH_W-1:0] flash_rdata,
    input logic [FLASH_CW-1:0] flash_rchk,
    output logic flash_dvalid,
    output logic [FLASH_W-1:0] flash_data,
    output logic flash_fixed,
    output logic flash_unlocked,
    input logic sram_rvalid,
    input logic [SRAM_W-1:0] sram_rdata,
    input logic [SRAM_CW-1:0] sram_rchk,
    input logic ecc_en,
    input logic par_en,
    output logic sram_dvalid,
    output logic [SRAM_W-1:0] sram_data,
    output logic sram_fixed,
    output logic sram_perr
);
    typedef struct packed {
        mmd_pkg::mmd_rsp_t f;
        mmd_pkg::mmd_rsp_t d;
        mmd_pkg::mmd_pw_t pw;
        logic fl_valid;
        logic [FLASH_W-1:0] fl_data;
        logic fl_fixed;
        logic sr_valid;
        logic [SRAM_W-1:0] sr_data;
        logic sr_fixed;
        logic sr_perr;
    } mmd_state_t;

    mmd_state_t st;
    mmd_state_t next_st;
    mmd_pkg::mmd_rsp_t nf;
    mmd_pkg::mmd_rsp_t nd;
    logic [FLASH_W-1:0] fl_fix;
    logic fl_err;
    logic [SRAM_W-1:0] sr_fix;
    logic sr_err;
    logic sr_par;
    logic unlocked;
    logic conflict;

    function automatic logic in_rng(input logic [23:0] a, input logic [23:0] lo,
                                    input logic [23:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

    function automatic mmd_pkg::mmd_tgt_t decode(input logic [23:0] a);
        decode = mmd_pkg::TGT_RSV;
        if (in_rng(a, mmd_pkg::IMB_LO, mmd_pkg::IMB_HI)) begin
            decode = mmd_pkg::TGT_IMB_REGS;
        end else if (in_rng(a, mmd_pkg::EPS_LO, mmd_pkg::EPS_MIR_HI)) begin
            decode = mmd_pkg::TGT_EMU_RAM;
        end else if (in_rng(a, mmd_pkg::PS_LO, mmd_pkg::PS_MIR_HI)) begin
            decode = mmd_pkg::TGT_PROG_RAM;
        end else if (in_rng(a, mmd_pkg::FL_LO, mmd_pkg::FL_HI)) begin
            decode = mmd_pkg::TGT_FLASH;
        end else if (in_rng(a, mmd_pkg::XM_LO, mmd_pkg::XM_HI)
                     || in_rng(a, mmd_pkg::IO_LO, mmd_pkg::IO_HI)
                     || in_rng(a, mmd_pkg::XL_LO, mmd_pkg::XL_HI)
                     || a <= mmd_pkg::DS_LO - 24'h000001) begin
            decode = mmd_pkg::TGT_EXT;
        end else if (in_rng(a, mmd_pkg::LX_LO, mmd_pkg::LX_HI)
                     && !in_rng(a, mmd_pkg::LX_GAP_LO, mmd_pkg::LX_GAP_HI)) begin
            decode = mmd_pkg::TGT_LOCAL_BUS;
        end else if (in_rng(a, mmd_pkg::SPF_LO, mmd_pkg::SPF_HI)) begin
            decode = mmd_pkg::TGT_SPECIAL;
        end else if (in_rng(a, mmd_pkg::DP_LO, mmd_pkg::DP_HI)) begin
            decode = mmd_pkg::TGT_DUAL_RAM;
        end else if (in_rng(a, mmd_pkg::EXF_LO, mmd_pkg::EXF_HI)) begin
            decode = mmd_pkg::TGT_EXTENDED;
        end else if (in_rng(a, mmd_pkg::XR_LO, mmd_pkg::XR_HI)) begin
            decode = mmd_pkg::TGT_XREG;
        end else if (in_rng(a, mmd_pkg::DS_LO, mmd_pkg::DS_HI)) begin
            decode = mmd_pkg::TGT_DATA_RAM;
        end
    endfunction

    // mirror windows fold onto base RAM
    function automatic logic [23:0] wrap(input logic [23:0] o);
        logic [23:0] w;
        w = o;
        for (int k = 0; k < mmd_pkg::MIRROR_WRAPS; k++) begin
            if (w >= mmd_pkg::RAM_SIZE) begin
                w = w - mmd_pkg::RAM_SIZE;
            end
        end
        return w;
    endfunction

    function automatic mmd_pkg::mmd_rsp_t build(input mmd_pkg::mmd_req_t rq,
                                                input logic fetch);
        mmd_pkg::mmd_rsp_t r;
        logic [23:0] a;
        logic [23:0] g;
        logic prog;
        r = '0;
        // word access uses the even byte
        a = {rq.addr[23:1], rq.addr[0] & ~rq.word};
        r.valid = rq.valid;
        r.wr = rq.write;
        r.tgt = decode(a);
        r.seg = a[23:16];
        r.page = a[15:14];
        r.off = a;
        case (r.tgt)
            mmd_pkg::TGT_PROG_RAM: begin
                r.off = wrap(a - mmd_pkg::PS_LO);
                r.mirror = a > mmd_pkg::PS_HI;
            end
            mmd_pkg::TGT_EMU_RAM: begin
                r.off = wrap(a - mmd_pkg::EPS_LO);
                r.mirror = a > mmd_pkg::EPS_HI;
            end
            mmd_pkg::TGT_FLASH: begin
                r.off = a - mmd_pkg::FL_LO;
                r.fmod = (a >= mmd_pkg::FL6_LO) ? mmd_pkg::FL6_MOD : r.off[20:18];
                r.fsec = r.off[17:12];
                r.fblk = r.off[11:7];
            end
            default: r.off = a;
        endcase
        if (r.tgt == mmd_pkg::TGT_RSV) begin
            r.ext_cycle = ext_bus_en;
            r.blocked = !ext_bus_en;
        end
        if (r.tgt == mmd_pkg::TGT_EXT) begin
            r.ext_cycle = 1'b1;
        end
        r.strict = in_rng(a, mmd_pkg::IO_LO, mmd_pkg::IO_HI);
        if (in_rng(a, mmd_pkg::CTL_LO, mmd_pkg::CTL_HI)) begin
            r.blocked = 1'b1;
        end
        prog = r.tgt inside {mmd_pkg::TGT_FLASH, mmd_pkg::TGT_PROG_RAM,
                             mmd_pkg::TGT_EMU_RAM};
        // data unit serves data side locally
        if (fetch) begin
            r.sys_bus = !prog;
        end else begin
            r.sys_bus = prog || r.ext_cycle || r.tgt == mmd_pkg::TGT_LOCAL_BUS;
        end
        if (r.tgt == mmd_pkg::TGT_PROG_RAM && rq.write
            && r.off < prog_ram_wp_size) begin
            r.blocked = 1'b1;
        end
        g = a - context_ptr;
        r.gpr_hit = r.tgt == mmd_pkg::TGT_DUAL_RAM && g <= mmd_pkg::GPR_LAST;
        r.general_purpose_register = g[4:1];
        r.bit_ok = (r.tgt == mmd_pkg::TGT_DUAL_RAM && (a >= mmd_pkg::DP_BIT_LO
                    || r.gpr_hit)) || r.tgt == mmd_pkg::TGT_SPECIAL
                   || r.tgt == mmd_pkg::TGT_EXTENDED;
        // byte halves only for R0 to R7
        if (r.gpr_hit && !rq.word && r.general_purpose_register > mmd_pkg::GPR_BYTE_MAX) begin
            r.blocked = 1'b1;
        end
        if (r.tgt == mmd_pkg::TGT_FLASH && !unlocked) begin
            // cluster bit guards program and erase
            if (rq.write && flash_wp[{r.fmod, r.fsec[5:2]}]) begin
                r.blocked = 1'b1;
            end
            if (!rq.write && !fetch && read_prot_en) begin
                r.blocked = 1'b1;
            end
        end
        return r;
    endfunction

    mmd_ecc #(
        .DW(FLASH_W),
        .CW(FLASH_CW)
    ) u_flash_ecc (
        .data(flash_rdata),
        .chk(flash_rchk),
        .fixed(fl_fix),
        .single_err(fl_err),
        .par_err()
    );

    mmd_ecc #(
        .DW(SRAM_W),
        .CW(SRAM_CW)
    ) u_sram_ecc (
        .data(sram_rdata),
        .chk(sram_rchk),
        .fixed(sr_fix),
        .single_err(sr_err),
        .par_err(sr_par)
    );

    assign unlocked = st.pw == mmd_pkg::PW_OPEN;
    always_comb nf = build(fetch_req, 1'b1);
    always_comb nd = build(data_req, 1'b0);
    // same module conflict stalls data side
    assign conflict = nf.valid && nd.valid && nf.tgt == mmd_pkg::TGT_FLASH
                      && nd.tgt == mmd_pkg::TGT_FLASH && nf.fmod == nd.fmod;
    assign fetch_ready = 1'b1;
    assign data_ready = !conflict;

    always_comb begin
        next_st = st;
        next_st.f = nf;
        next_st.d = nd;
        next_st.d.valid = nd.valid && !conflict;
        case (st.pw)
            mmd_pkg::PW_LOCKED: begin
                if (pw_strobe && pw_word == pw_key[31:16]) begin
                    next_st.pw = mmd_pkg::PW_HALF;
                end
            end
            mmd_pkg::PW_HALF: begin
                if (pw_strobe) begin
                    next_st.pw = (pw_word == pw_key[15:0]) ? mmd_pkg::PW_OPEN
                                                            : mmd_pkg::PW_LOCKED;
                end
            end
            mmd_pkg::PW_OPEN: next_st.pw = mmd_pkg::PW_OPEN;
            default: next_st.pw = mmd_pkg::PW_LOCKED;
        endcase
        if (relock) begin
            next_st.pw = mmd_pkg::PW_LOCKED;
        end
        next_st.fl_valid = flash_rvalid;
        next_st.fl_data = fl_fix;
        next_st.fl_fixed = flash_rvalid && fl_err;
        next_st.sr_valid = sram_rvalid;
        next_st.sr_data = sram_rdata;
        next_st.sr_fixed = 1'b0;
        next_st.sr_perr = 1'b0;
        if (ecc_en) begin
            next_st.sr_data = sr_fix;
            next_st.sr_fixed = sram_rvalid && sr_err;
        end else if (par_en && sr_par) begin
            next_st.sr_valid = 1'b0;
            next_st.sr_perr = sram_rvalid;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign fetch_rsp = st.f;
    assign data_rsp = st.d;
    assign flash_dvalid = st.fl_valid;
    assign flash_data = st.fl_data;
    assign flash_fixed = st.fl_fixed;
    assign flash_unlocked = unlocked;
    assign sram_dvalid = st.sr_valid;
    assign sram_data = st.sr_data;
    assign sram_fixed = st.sr_fixed;
    assign sram_perr = st.sr_perr;

    chk_ctrl_sector: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_req.valid && in_rng(fetch_req.addr, mmd_pkg::CTL_LO, mmd_pkg::CTL_HI)
        |=> fetch_rsp.valid && fetch_rsp.blocked)
        else $error("control sector access not blocked");

    chk_io_strict: assert property (
        @(posedge clk) disable iff (!reset_n)
        data_req.valid && data_ready
        && in_rng(data_req.addr, mmd_pkg::IO_LO, mmd_pkg::IO_HI)
        |=> data_rsp.strict && data_rsp.ext_cycle && !data_rsp.blocked)
        else $error("external IO access not strict");

    chk_rsv_route: assert property (
        @(posedge clk) disable iff (!reset_n)
        data_rsp.valid && data_rsp.tgt == mmd_pkg::TGT_RSV
        |-> data_rsp.ext_cycle == $past(ext_bus_en) && data_rsp.blocked == !data_rsp.ext_cycle)
        else $error("reserved access routed wrongly");

    chk_sys_seg: assert property (
        @(posedge clk) disable iff (!reset_n)
        data_rsp.valid && data_rsp.tgt inside {mmd_pkg::TGT_DATA_RAM,
            mmd_pkg::TGT_DUAL_RAM, mmd_pkg::TGT_SPECIAL, mmd_pkg::TGT_EXTENDED}
        |-> data_rsp.seg == 8'h00)
        else $error("system target outside segment 0");

    chk_ram_wp: assert property (
        @(posedge clk) disable iff (!reset_n)
        data_rsp.valid && data_rsp.wr && data_rsp.tgt == mmd_pkg::TGT_PROG_RAM
        && data_rsp.off < $past(prog_ram_wp_size) |-> data_rsp.blocked)
        else $error("protected program RAM write passed");

    chk_flash_par: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_req.valid && data_req.valid && nf.tgt == mmd_pkg::TGT_FLASH
        && nd.tgt == mmd_pkg::TGT_FLASH && nf.fmod != nd.fmod
        |-> data_ready ##1 fetch_rsp.valid && data_rsp.valid)
        else $error("parallel Flash modules stalled");

    chk_fetch_local: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_rsp.valid && fetch_rsp.tgt inside {mmd_pkg::TGT_FLASH,
            mmd_pkg::TGT_PROG_RAM} |-> !fetch_rsp.sys_bus)
        else $error("program fetch sent over system bus");

    chk_pw_unlock: assert property (
        @(posedge clk) disable iff (!reset_n)
        st.pw == mmd_pkg::PW_LOCKED && pw_strobe && pw_word == pw_key[31:16] && !relock
        ##1 pw_strobe && pw_word == pw_key[15:0] && !relock
        |=> flash_unlocked)
        else $error("password sequence did not unlock");

    chk_sram_par: assert property (
        @(posedge clk) disable iff (!reset_n)
        sram_rvalid && par_en && !ecc_en && sr_par
        |=> !sram_dvalid && sram_perr)
        else $error("parity error data was released");

    chk_mirror_off: assert property (
        @(posedge clk) disable iff (!reset_n)
        fetch_rsp.valid && fetch_rsp.mirror |-> fetch_rsp.off < mmd_pkg::RAM_SIZE)
        else $error("mirror offset beyond base RAM");
endmodule

/* File: dv/mmd_mem_model.sv */
/*
 * Read-return model of an on-chip Flash or SRAM.
 * Assumes reads on clk; data returns at the next edge.
 */
`timescale 1ns/100ps
module mmd_mem_model #(
    parameter int DW = 16,
    parameter int CW = 5
) (
    input logic clk,
    input logic rd,
    input logic [DW-1:0] wd,
    input logic [DW-1:0] flip,
    output logic rvalid,
    output logic [DW-1:0] rdata,
    output logic [CW-1:0] rchk
);
    // Check bit k covers code positions with bit k set
    function automatic logic [CW-1:0] ham(input logic [DW-1:0] d);
        int p;
        int j;
        logic [CW-1:0] c;
        c = '0;
        j = 0;
        for (p = 1; j < DW; p++) begin
            if ((p & (p - 1)) != 0) begin
                c = c ^ (d[j] ? p[CW-1:0] : '0);
                j++;
            end
        end
        return c;
    endfunction

    initial begin
        rvalid = 1'h0;
        rdata = '0;
        rchk = '0;
    end

    always @(posedge clk) begin
        rvalid <= rd;
        if (rd) begin
            rdata <= wd ^ flip;
            rchk <= ham(wd);
        end else begin
            rdata <= ~rdata;
            rchk <= ~rchk;
        end
    end
endmodule

/* File: dv/memory_map_decoder_tb.sv */
/*
 * Self-checking bench for the memory map decoder: region table, then
 * protection, password, conflict, GENERAL_PURPOSE_REGISTER and read-check cases.
 * Assumes a 40 MHz clock and inputs driven at the falling edge.
 */
`timescale 1ns/100ps
module memory_map_decoder_tb;
    typedef struct packed {
        logic [23:0] a;
        mmd_pkg::mmd_tgt_t t;
        logic ext;
        logic strict;
        logic mir;
        logic [23:0] off;
    } mmd_row_t;
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    mmd_pkg::mmd_req_t fetch_req = '0;
    mmd_pkg::mmd_req_t data_req = '0;
    mmd_pkg::mmd_rsp_t fetch_rsp;
    mmd_pkg::mmd_rsp_t data_rsp;
    mmd_pkg::mmd_rsp_t r;
    logic fetch_ready, data_ready, flash_dvalid, flash_fixed, flash_unlocked;
    logic sram_dvalid, sram_fixed, sram_perr, flash_rvalid, sram_rvalid;
    logic ext_bus_en = 1'h1;
    logic read_prot_en = 1'h0;
    logic pw_strobe = 1'h0;
    logic relock = 1'h0;
    logic ecc_en = 1'h0;
    logic par_en = 1'h0;
    logic f_rd = 1'h0;
    logic s_rd = 1'h0;
    logic [23:0] context_ptr = 24'h00f600;
    logic [23:0] prog_ram_wp_size = 24'h0;
    logic [mmd_pkg::CLUS_W-1:0] flash_wp = '0;
    logic [15:0] pw_word = 16'h0;
    logic [31:0] pw_key = 32'h1234abcd;
    logic [127:0] f_wd = 128'h0;
    logic [127:0] f_flip = 128'h0;
    logic [127:0] flash_rdata, flash_data;
    logic [15:0] s_wd = 16'h0;
    logic [15:0] s_flip = 16'h0;
    logic [15:0] sram_rdata, sram_data;
    logic [7:0] flash_rchk;
    logic [4:0] sram_rchk;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    mmd_row_t rows[17] = '{
        '{24'hffff00, mmd_pkg::TGT_IMB_REGS, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'he80000, mmd_pkg::TGT_EMU_RAM, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'he9c000, mmd_pkg::TGT_EMU_RAM, 1'h0, 1'h0, 1'h1, 24'h0},
        '{24'he1c004, mmd_pkg::TGT_PROG_RAM, 1'h0, 1'h0, 1'h1, 24'h4},
        '{24'hc00000, mmd_pkg::TGT_FLASH, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'hd80000, mmd_pkg::TGT_FLASH, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h400000, mmd_pkg::TGT_EXT, 1'h1, 1'h0, 1'h0, 24'h0},
        '{24'h210000, mmd_pkg::TGT_EXT, 1'h1, 1'h1, 1'h0, 24'h0},
        '{24'h3ffffe, mmd_pkg::TGT_EXT, 1'h1, 1'h1, 1'h0, 24'h0},
        '{24'h1ffffe, mmd_pkg::TGT_EXT, 1'h1, 1'h0, 1'h0, 24'h0},
        '{24'h200000, mmd_pkg::TGT_LOCAL_BUS, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h00fe00, mmd_pkg::TGT_SPECIAL, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h00f800, mmd_pkg::TGT_DUAL_RAM, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h00f000, mmd_pkg::TGT_EXTENDED, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h00e000, mmd_pkg::TGT_XREG, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h008000, mmd_pkg::TGT_DATA_RAM, 1'h0, 1'h0, 1'h0, 24'h0},
        '{24'h000000, mmd_pkg::TGT_EXT, 1'h1, 1'h0, 1'h0, 24'h0}};

    always #12.5 clk = ~clk;

    mmd_decoder mmd_decoder_i (.clk(clk), .reset_n(reset_n), .fetch_req(fetch_req),
        .data_req(data_req), .fetch_ready(fetch_ready), .data_ready(data_ready),
        .fetch_rsp(fetch_rsp), .data_rsp(data_rsp), .ext_bus_en(ext_bus_en),
        .context_ptr(context_ptr), .prog_ram_wp_size(prog_ram_wp_size),
        .flash_wp(flash_wp), .read_prot_en(read_prot_en), .pw_strobe(pw_strobe),
        .pw_word(pw_word), .pw_key(pw_key), .relock(relock), .flash_rvalid(flash_rvalid),
        .flash_rdata(flash_rdata), .flash_rchk(flash_rchk), .flash_dvalid(flash_dvalid),
        .flash_data(flash_data), .flash_fixed(flash_fixed), .flash_unlocked(flash_unlocked),
        .sram_rvalid(sram_rvalid), .sram_rdata(sram_rdata), .sram_rchk(sram_rchk),
        .ecc_en(ecc_en), .par_en(par_en), .sram_dvalid(sram_dvalid), .sram_data(sram_data),
        .sram_fixed(sram_fixed), .sram_perr(sram_perr));
    mmd_mem_model #(.DW(128), .CW(8)) mmd_mem_model_i (.clk(clk), .rd(f_rd), .wd(f_wd),
        .flip(f_flip), .rvalid(flash_rvalid), .rdata(flash_rdata), .rchk(flash_rchk));
    mmd_mem_model #(.DW(16), .CW(5)) mmd_mem_model_s_i (.clk(clk), .rd(s_rd), .wd(s_wd),
        .flip(s_flip), .rvalid(sram_rvalid), .rdata(sram_rdata), .rchk(sram_rchk));

    task automatic chk(input string nm, input logic [129:0] e, input logic [129:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_tgt(input mmd_pkg::mmd_tgt_t e, input mmd_pkg::mmd_tgt_t g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] tgt expected %h seen %h", e, g);
        end
    endtask

    task wrap_up;
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic acc(input logic f, input logic [23:0] a, input logic w, input logic wd);
        if (f) fetch_req = '{1'h1, w, wd, a};
        else data_req = '{1'h1, w, wd, a};
        @(posedge clk);
        fetch_req.valid <= 1'h0;
        data_req.valid <= 1'h0;
        @(negedge clk);
        r = f ? fetch_rsp : data_rsp;
    endtask

    task automatic pw(input logic [15:0] w);
        pw_word = w;
        pw_strobe = 1'h1;
        @(posedge clk);
        pw_strobe <= 1'h0;
        @(negedge clk);
    endtask

    task automatic memrd(input logic f);
        if (f) f_rd = 1'h1;
        else s_rd = 1'h1;
        @(posedge clk);
        f_rd <= 1'h0;
        s_rd <= 1'h0;
        @(posedge clk);
        @(negedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            wrap_up;
        end
    end

    initial begin
        repeat (2) @(negedge clk);
        chk("fetch_ready", 1, fetch_ready);
        chk("rsp_valid_in_reset", 0, data_rsp.valid);
        reset_n = 1'h1;
        foreach (rows[i]) begin
            acc(1'h0, rows[i].a, 1'h0, ~i[0]);
            chk_tgt(rows[i].t, r.tgt);
            chk("ext_cycle", rows[i].ext, r.ext_cycle);
            chk("strict", rows[i].strict, r.strict);
            chk("blocked", 0, r.blocked);
            chk("seg_page", {rows[i].a[23:16], rows[i].a[15:14]}, {r.seg, r.page});
            chk("mirror", rows[i].mir, r.mirror);
            if (rows[i].mir) chk("off", rows[i].off, r.off);
            if (rows[i].t == mmd_pkg::TGT_FLASH) chk("fmod", 3'(rows[i].a[23:18] - 6'h30), r.fmod);
        end
        acc(1'h1, 24'hc0f000, 1'h0, 1'h1);
        chk("ctl_blocked", 1, r.blocked);
        ext_bus_en = 1'h0;
        acc(1'h0, 24'hf00000, 1'h0, 1'h1);
        chk("rsv_ext", 0, r.ext_cycle);
        chk("rsv_blocked", 1, r.blocked);
        ext_bus_en = 1'h1;
        acc(0, 24'h20b000, 1'h0, 1'h1);
        chk("sys_bus", 1, r.sys_bus);
        acc(0, 24'h206800, 1'h0, 1'h1);
        chk("gap_ext", 1, r.ext_cycle);
        prog_ram_wp_size = 24'h100;
        acc(0, 24'he000fe, 1'h1, 1'h1);
        chk("wp_in", 1, r.blocked);
        acc(0, 24'he00100, 1'h1, 1'h1);
        chk("wp_out", 0, r.blocked);
        flash_wp[16] = 1'h1;
        acc(0, 24'hc40000, 1'h1, 1'h1);
        chk("clus_blocked", 1, r.blocked);
        acc(0, 24'hc50f80, 1'h1, 1'h1);
        chk("clus_free", 0, r.blocked);
        chk("sec_blk", {6'h10, 5'h1f}, {r.fsec, r.fblk});
        read_prot_en = 1'h1;
        acc(0, 24'hc40000, 1'h0, 1'h1);
        chk("rp_blocked", 1, r.blocked);
        pw(pw_key[31:16]);
        pw(16'h0bad);
        chk("pw_wrong", 0, flash_unlocked);
        pw(pw_key[31:16]);
        pw(pw_key[15:0]);
        chk("pw_open", 1, flash_unlocked);
        acc(0, 24'hc40000, 1'h0, 1'h1);
        chk("rp_open", 0, r.blocked);
        relock = 1'h1;
        @(posedge clk);
        relock <= 1'h0;
        @(negedge clk);
        chk("relocked", 0, flash_unlocked);
        read_prot_en = 1'h0;
        fetch_req = '{1'h1, 1'h0, 1'h1, 24'hc00000};
        data_req = '{1'h1, 1'h0, 1'h1, 24'hc40000};
        #1 chk("ready_par", 1, data_ready);
        @(negedge clk) chk("par_go", 1, data_rsp.valid);
        data_req.addr = 24'hc00100;
        #1 chk("ready_conf", 0, data_ready);
        @(negedge clk) chk("conf_out", 0, data_rsp.valid);
        fetch_req.valid = 1'h0;
        acc(0, 24'h00f602, 1'h0, 1'h1);
        chk("gpr1", {1'h1, 4'h1}, {r.gpr_hit, r.general_purpose_register});
        acc(0, 24'h00f610, 1'h0, 1'h0);
        chk("gpr8_byte", 1, r.blocked);
        acc(0, 24'h00fd00, 1'h0, 1'h1);
        chk("bit_top", 1, r.bit_ok);
        acc(0, 24'h00f700, 1'h0, 1'h1);
        chk("bit_low", 0, r.bit_ok);
        f_wd = 128'h0123456789abcdef_fedcba9876543210;
        f_flip = 128'h1 << 77;
        memrd(1'h1);
        chk("flash_fix", {1'h1, 1'h1, f_wd}, {flash_dvalid, flash_fixed, flash_data});
        ecc_en = 1'h1;
        s_wd = 16'h5a3c;
        s_flip = 16'h0010;
        memrd(1'h0);
        chk("sram_ecc", {1'h1, 1'h1, 16'h5a3c}, {sram_dvalid, sram_fixed, sram_data});
        ecc_en = 1'h0;
        par_en = 1'h1;
        s_wd = 16'h0;
        s_flip = 16'h0;
        memrd(1'h0);
        chk("par_ok", {1'h1, 1'h0}, {sram_dvalid, sram_perr});
        s_flip = 16'h0008;
        memrd(1'h0);
        chk("par_err", {1'h0, 1'h1}, {sram_dvalid, sram_perr});
        wrap_up;
    end
endmodule
